//--- hdl/interrupt_flag_status.sv
/*
 interrupt_flag_status: two identical read-only interrupt flag registers
 behind an AHB-Lite slave, a write-1-to-clear register, and the sequence
 break-attempt detector. Both flag registers read one shared set of flags.
 Assumes single word transfers with no wait states, one clock hclk, and
 source event pulses and sequence lines that are synchronous to hclk.
 Assumes hreadyout is the bus's hready when this is the only slave.
*/
// Contract
// (R1) first flag register at 0x3010, resets zero
// (R2) identical second flag register at 0x3014, resets zero
// (R3) bit 31 sets on request during sequence
// (R4) such request is dropped, first sequence continues
// (R5) outlier status in bit 29
// (R6) fifo underflow status in bit 27
// (R7) fifo overflow status in bit 26
// (R8) bits read 1 asserted, read-only
// (R9) write 1 to clear register clears flag
// (R10) bits 30, 28 zero; flag writes ignored
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status
   import flag_status_pkg::*;
(
   input wire logic hclk, // 250 MHz clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [15:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size, word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // always ready
   output logic [1:0] hresp, // always okay
   input wire logic seq_a_running, // first sequence executing
   input wire logic seq_b_request, // one-cycle request for second sequence
   input wire logic outlier_event, // outlier detected pulse
   input wire logic fifo_underflow_event, // fifo underflow pulse
   input wire logic fifo_overflow_event, // fifo overflow pulse
   output logic seq_b_start // accepted second sequence start pulse
);
   // flag storage and the value it takes at the next edge
   logic [31:0] flags; // one shared copy behind both flag registers
   logic [31:0] next_flags; // flags after this cycle's sets and clears
   // record of the previous cycle's address phase, used in its data phase
   logic ph_write; // accepted transfer was a write
   logic [15:0] ph_addr; // byte address of the previous cycle, accepted or not

   // compares a byte address with a register offset
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
      addr_hit = (addr == offset);
   endfunction : addr_hit

   // puts the source lines at their flag positions, all other bits zero
   function automatic logic [31:0] place_sources(input logic brk, input logic outl,
      input logic under, input logic over);
      logic [31:0] placed;
      placed = flags_reset;
      placed[bit_break] = brk;
      placed[bit_outlier] = outl;
      placed[bit_underflow] = under;
      placed[bit_overflow] = over;
      place_sources = placed;
   endfunction : place_sources

   // a transfer is taken when selected, ready and not idle or busy
   wire trans_live = (htrans == htrans_nonseq) | (htrans == htrans_seq);
   wire addr_valid = hsel & hready & trans_live;
   wire read_take = addr_valid & ~hwrite; // read address phase accepted

   // register selection, in the address phase and in the data phase
   wire hit_flags_0 = addr_hit(haddr, off_flags_0); // R1
   wire hit_flags_1 = addr_hit(haddr, off_flags_1); // R2
   wire is_flags = hit_flags_0 | hit_flags_1; // R1 R2
   wire ph_hit_clear = addr_hit(ph_addr, off_clear); // R9
   wire ph_hit_flags = addr_hit(ph_addr, off_flags_0) | addr_hit(ph_addr, off_flags_1);

   // write-1-to-clear mask, live in the data phase of a clear write
   wire wr_clear = ph_write & ph_hit_clear; // R9
   wire [31:0] clear_bits = wr_clear ? (hwdata & flags_mask) : '0; // R9

   // a second-sequence request is dropped while the first runs
   wire break_attempt = seq_b_request & seq_a_running; // R3
   wire start_ok = seq_b_request & ~seq_a_running; // R4

   // source lines gathered into their flag positions
   wire [31:0] set_bits = place_sources(break_attempt, outlier_event,
      fifo_underflow_event, fifo_overflow_event); // R3 R5 R6 R7

   // set wins over clear; reserved bits forced zero
   assign next_flags = ((flags & ~clear_bits) | set_bits) & flags_mask; // R8 R10

   // named views of the stored status bits
   wire break_attempt_status = flags[bit_break]; // R3
   wire outlier_status = flags[bit_outlier]; // R5
   wire fifo_underflow_status = flags[bit_underflow]; // R6
   wire fifo_overflow_status = flags[bit_overflow]; // R7

   // read data for the coming data phase; other reads and writes give zero
   wire [31:0] read_value = (read_take & is_flags) ? next_flags : '0; // R2 R8

   // bus answers: no wait states, never an error
   assign hreadyout = 1'b1;
   assign hresp = hresp_okay;

   // second sequence only starts when the first is idle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         seq_b_start <= 1'b0;
      else
         seq_b_start <= start_ok; // R4
   end

   // flag storage; flag registers themselves ignore writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags <= flags_reset; // R1 R2
      else
         flags <= next_flags; // R10
   end

   // data phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_write <= 1'b0;
         ph_addr <= '0;
         hrdata <= flags_reset;
      end
      else
      begin
         ph_write <= addr_valid & hwrite;
         ph_addr <= haddr;
         hrdata <= read_value; // R8
      end
   end

   // a break attempt shows in the break flag at the next edge
   property p_break_sets;
      @(posedge hclk) disable iff (!hresetn)
      break_attempt |=> break_attempt_status;
   endproperty : p_break_sets
   a_break_sets : assert property (p_break_sets) else $error("break flag not set"); // R3

   // the break flag never rises without a break attempt
   property p_break_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (!break_attempt_status && !(seq_b_request && seq_a_running)) |=> !break_attempt_status;
   endproperty : p_break_quiet
   a_break_quiet : assert property (p_break_quiet) else $error("stray break flag"); // R3

   // no start is granted while the first sequence runs
   property p_no_start_busy;
      @(posedge hclk) disable iff (!hresetn)
      (seq_b_request && seq_a_running) |=> !seq_b_start;
   endproperty : p_no_start_busy
   a_no_start_busy : assert property (p_no_start_busy) else $error("start while busy"); // R4

   // an idle first sequence lets the request start the second
   property p_start;
      @(posedge hclk) disable iff (!hresetn)
      (seq_b_request && !seq_a_running) |=> seq_b_start;
   endproperty : p_start
   a_start : assert property (p_start) else $error("start lost"); // R4

   // an outlier pulse shows in the outlier flag at the next edge
   property p_outlier;
      @(posedge hclk) disable iff (!hresetn)
      outlier_event |=> outlier_status;
   endproperty : p_outlier
   a_outlier : assert property (p_outlier) else $error("outlier flag missed"); // R5

   // the outlier flag never rises without an outlier pulse
   property p_outlier_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (!outlier_status && !outlier_event) |=> !outlier_status;
   endproperty : p_outlier_quiet
   a_outlier_quiet : assert property (p_outlier_quiet) else $error("stray outlier flag"); // R5

   // an underflow pulse shows in the underflow flag at the next edge
   property p_under;
      @(posedge hclk) disable iff (!hresetn)
      fifo_underflow_event |=> fifo_underflow_status;
   endproperty : p_under
   a_under : assert property (p_under) else $error("underflow flag missed"); // R6

   // an overflow pulse shows in the overflow flag at the next edge
   property p_over;
      @(posedge hclk) disable iff (!hresetn)
      fifo_overflow_event |=> fifo_overflow_status;
   endproperty : p_over
   a_over : assert property (p_over) else $error("overflow flag missed"); // R7

   // reserved flag positions stay zero
   property p_reserved;
      @(posedge hclk) disable iff (!hresetn)
      (flags & ~flags_mask) == '0;
   endproperty : p_reserved
   a_reserved : assert property (p_reserved) else $error("reserved bit set"); // R10

   // a write to a flag register leaves the flags as they were
   property p_wr_ignored;
      @(posedge hclk) disable iff (!hresetn)
      (ph_write && ph_hit_flags && set_bits == '0) |=> $stable(flags);
   endproperty : p_wr_ignored
   a_wr_ignored : assert property (p_wr_ignored) else $error("flag write took effect"); // R10

   // a 1 written to the clear register clears the flag
   property p_clear;
      @(posedge hclk) disable iff (!hresetn)
      (wr_clear && hwdata[bit_outlier] && !outlier_event) |=> !outlier_status;
   endproperty : p_clear
   a_clear : assert property (p_clear) else $error("clear ignored"); // R9

   // a set flag stays set until it is cleared
   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      (!wr_clear && fifo_overflow_status) |=> fifo_overflow_status;
   endproperty : p_hold
   a_hold : assert property (p_hold) else $error("flag lost without clear"); // R8

   // read data stands one data phase only, zero otherwise
   property p_read_idle;
      @(posedge hclk) disable iff (!hresetn)
      !read_take |=> hrdata == '0;
   endproperty : p_read_idle
   a_read_idle : assert property (p_read_idle) else $error("read data not zero"); // R8
endmodule : interrupt_flag_status
`default_nettype wire

//--- hdl/flag_status_pkg.sv
/*
 flag_status_pkg: register offsets, bit positions and reset values for the
 interrupt flag status block.
 Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
*/
package flag_status_pkg;
   localparam logic [15:0] off_flags_0 = 16'h3010; // first flag register
   localparam logic [15:0] off_flags_1 = 16'h3014; // second flag register
   localparam logic [15:0] off_clear = 16'h3004; // clear register, write 1 to clear
   localparam logic [15:0] off_seq_ctrl = 16'h3020; // sequence request / status, not decoded by the slave, reads zero
   localparam logic [31:0] flags_reset = 32'h00000000;
   localparam int bit_break = 31;
   localparam int bit_outlier = 29;
   localparam int bit_underflow = 27;
   localparam int bit_overflow = 26;
   localparam logic [31:0] flags_mask = 32'hac000000; // implemented flag bits
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [1:0] htrans_seq = 2'h3;
   localparam logic [1:0] hresp_okay = 2'h0;
endpackage : flag_status_pkg

//--- testbench/interrupt_flag_status_tb_top.sv
/* bench for interrupt_flag_status: flag reads, clears, events, sequence requests.
 assumes a zero-wait AHB-Lite slave whose hreadyout is looped back as hready. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status_tb_top
   import flag_status_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0, req = 1'b0;
   logic [15:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [2:0] ev = '0;
   logic [31:0] hwdata = '0, rd;
   wire logic [31:0] hrdata;
   wire logic hreadyout, start;
   wire logic [1:0] hresp;
   int errors = 0, checks_done = 0, cyc = 0;
   interrupt_flag_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seq_a_running(run),
      .seq_b_request(req), .outlier_event(ev[2]), .fifo_underflow_event(ev[1]),
      .fifo_overflow_event(ev[0]), .seq_b_start(start));
   // 4 ns clock and a hang limit
   initial
   begin
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         errors++;
         wrap_up();
      end
   end
   // compare, single bus transfer, verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask : chk
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= htrans_nonseq;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk({30'h0, hresp}, {30'h0, hresp_okay});
   endtask : bus
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // reset, sources alone, flag writes, clears, sequence requests, reset again
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, off_flags_0, 32'h0);
      chk(rd, flags_reset);
      bus(1'b0, off_flags_1, 32'h0);
      chk(rd, flags_reset);
      for (int i = 0; i < 3; i++)
      begin
         ev <= 3'h1 << i;
         @(posedge hclk);
         ev <= 3'h0;
         bus(1'b1, off_flags_0, 32'hffffffff);
         bus(1'b1, off_clear, 32'h0);
         bus(1'b0, off_flags_1, 32'h0);
         chk(rd, 32'h1 << (i == 2 ? bit_outlier : bit_overflow + i));
         @(posedge hclk);
         chk(hrdata, 32'h0);
         bus(1'b1, off_clear, flags_mask);
         bus(1'b0, off_flags_0, 32'h0);
         chk(rd, flags_reset);
      end
      for (int k = 0; k < 2; k++)
      begin
         run <= k[0];
         req <= 1'b1;
         @(posedge hclk);
         req <= 1'b0;
         @(posedge hclk);
         chk({31'h0, start}, {31'h0, ~k[0]});
         bus(1'b0, off_flags_0, 32'h0);
         chk(rd, {k[0], 31'h0});
      end
      // clear of the break flag while an outlier pulse lands: the set wins
      fork
         bus(1'b1, off_clear, flags_mask);
         begin
            @(posedge hclk);
            ev <= 3'h4;
            @(posedge hclk);
            ev <= 3'h0;
         end
      join
      bus(1'b0, off_flags_1, 32'h0);
      chk(rd, 32'h1 << bit_outlier);
      bus(1'b0, off_seq_ctrl, 32'h0);
      chk(rd, 32'h0);
      // reset in mid-run returns every flag to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(hrdata, 32'h0);
      bus(1'b0, off_flags_0, 32'h0);
      chk(rd, flags_reset);
      bus(1'b0, off_flags_1, 32'h0);
      chk(rd, flags_reset);
      wrap_up();
   end
endmodule : interrupt_flag_status_tb_top
`default_nettype wire
